// ===== src/fdcr_regs.sv
`timescale 1ns/1ps
// floppy drive control registers: status b, output control, tape assign
// What this block does
// - basic mode leaves data undriven on status b reads; other modes readable.
// - enhanced status b bits 1:0 show motor outputs; only bus reset clears.
// - enhanced status b bit 3 toggles on each read-data inactive edge.
// - enhanced status b bit 4 toggles on each write-data inactive edge.
// - enhanced bit 5 mirrors drive number bit 0; bit 2 shows live write gate.
// - enhanced status b bits 7:6 always read one.
// - legacy status b bits 1:0 read one; bit 7 unsupported drive-2 input.
// - legacy bit 2 set on write gate rising, cleared by digital input read.
// - legacy bit 3 set on read-data inactive edge, cleared by input read.
// - legacy bit 4 set on write-data inactive edge regardless of write gate.
// - legacy bits 6:5 show active-low select outputs, reset to one.
// - output control writable anytime, zero on bus reset, kept by soft reset.
// - output control bits 1:0 are binary drive number, one select at most.
// - bit 2 zero holds controller reset; other registers unchanged.
// - soft reset lasts at least 100ns; back-to-back clear/set honoured.
// - bit 3 gates dma and interrupts in basic and legacy; always on enhanced.
// - bits 5:4 drive motor outputs 0 and 1; bits 7:6 unused.
// - normal decode selects drive 0 or 1 low when its motor bit set.
// - swapped decode exchanges select outputs and motor outputs.
// - tape assign bits 1:0 select tape drive 0 to 3, soft reset ignored.
// - enhanced floppy mode tape reads give type id 5:4 and boot drive 3:2.
// - drive type id is the config pair selected by drive number.
module fdcr_regs
    import fdcr_pkg::*;
(
    input wire logic clk_sys_i, // 250 MHz system clock
    input wire logic rst_i, // hardware bus reset, sync, active high
    input wire logic [9:0] addr_i, // host i/o address
    input wire logic rd_i, // host read strobe, one cycle
    input wire logic wr_i, // host write strobe, one cycle
    input wire logic [7:0] wdata_i, // host write data
    input wire fdcr_mode_t mode_i, // interface mode, static
    input wire logic swap_i, // drives 0 and 1 swapped, static
    input wire logic enh_floppy_i, // enhanced floppy mode 2, static
    input wire logic [7:0] drive_type_cfg_i, // config register f2 of logical device 0
    input wire logic [1:0] boot_drive_i, // floppy boot drive, static
    input wire logic write_gate_i, // write gate from core, same clock
    input wire logic read_data_n_i, // read data pin from drive, active low
    input wire logic write_data_n_i, // write data from core, active low
    input wire logic second_drive_present_n_i, // drive 2 input, unsupported
    input wire logic dma_req_i, // dma request from core
    input wire logic irq_i, // interrupt from core
    output logic [7:0] rdata_o, // host read data
    output logic rdata_oe_n_o, // read data enable, low while driving
    output logic select_out_0_n_o, // drive 0 select, active low
    output logic select_out_1_n_o, // drive 1 select, active low
    output logic motor_out_0_n_o, // motor 0, active low
    output logic motor_out_1_n_o, // motor 1, active low
    output logic soft_reset_o, // controller reset to core, active high
    output logic dma_req_o, // gated dma request
    output logic irq_o, // gated interrupt
    output logic [1:0] tape_sel_o // tape drive number
);
    // ----------------------------------------
    // host strobes and pin synchronisers
    // ----------------------------------------
    logic [7:0] out_ctrl_q;
    logic [1:0] tape_q;
    logic wg_last_q;
    logic rd_tog_q;
    logic wd_tog_q;
    logic wg_latch_q;
    logic rd_latch_q;
    logic wd_latch_q;
    logic [7:0] status_b;
    logic [1:0] type_id;
    logic [7:0] rdata_d;
    logic oe_n_d;
    logic sel0_n;
    logic sel1_n;
    logic mot0_n;
    logic mot1_n;
    logic [7:0] srst_cnt_q;
    logic rd_rise;
    logic wd_rise;
    logic drv2_meta_q;
    logic drv2_q;
    logic dig_in_rd;

    // inactive edge of an active-low data line is its rising edge
    fdcr_edge_sync u_rd_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(read_data_n_i),
        .rise_o(rd_rise),
        .fall_o()
    );

    // write data is on our clock but synchronising costs only latency
    fdcr_edge_sync u_wd_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(write_data_n_i),
        .rise_o(wd_rise),
        .fall_o()
    );

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            drv2_meta_q <= 1'b1;
            drv2_q <= 1'b1;
        end else begin
            drv2_meta_q <= second_drive_present_n_i;
            drv2_q <= drv2_meta_q;
        end
    end

    assign dig_in_rd = rd_i && (addr_i == FDCR_ADDR_DIG_IN);

    // ----------------------------------------
    // output control and tape registers
    // ----------------------------------------
    // only the bus reset clears these; the soft reset never reaches them
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            out_ctrl_q <= FDCR_OUT_CTRL_RST;
        end else if (wr_i && addr_i == FDCR_ADDR_OUT_CTRL) begin
            out_ctrl_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tape_q <= FDCR_TAPE_RST;
        end else if (wr_i && addr_i == FDCR_ADDR_TAPE) begin
            tape_q <= wdata_i[1:0];
        end
    end

    // ----------------------------------------
    // soft reset stretch
    // ----------------------------------------
    // a clear then set on consecutive writes still gives the full minimum
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            srst_cnt_q <= 8'h00;
        end else if (!out_ctrl_q[FDCR_BIT_SRST_N]) begin
            srst_cnt_q <= 8'(FDCR_SRST_MIN_CYC);
        end else if (srst_cnt_q != 8'h00) begin
            srst_cnt_q <= srst_cnt_q - 8'h01;
        end
    end

    // ----------------------------------------
    // drive decode
    // ----------------------------------------
    always_comb begin
        sel0_n = 1'b1;
        sel1_n = 1'b1;
        // only one select can win since the drive number is binary
        if (out_ctrl_q[1:0] == 2'h0 && out_ctrl_q[FDCR_BIT_MOTOR0]) begin
            if (swap_i) sel1_n = 1'b0;
            else sel0_n = 1'b0;
        end else if (out_ctrl_q[1:0] == 2'h1 && out_ctrl_q[FDCR_BIT_MOTOR1]) begin
            if (swap_i) sel0_n = 1'b0;
            else sel1_n = 1'b0;
        end
        mot0_n = swap_i ? ~out_ctrl_q[FDCR_BIT_MOTOR1] : ~out_ctrl_q[FDCR_BIT_MOTOR0];
        mot1_n = swap_i ? ~out_ctrl_q[FDCR_BIT_MOTOR0] : ~out_ctrl_q[FDCR_BIT_MOTOR1];
    end

    // ----------------------------------------
    // status b toggles and latches
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wg_last_q <= 1'b0;
            rd_tog_q <= 1'b0;
            wd_tog_q <= 1'b0;
        end else begin
            wg_last_q <= write_gate_i;
            if (rd_rise) rd_tog_q <= ~rd_tog_q;
            if (wd_rise) wd_tog_q <= ~wd_tog_q;
        end
    end

    // a latching edge in the clearing cycle wins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wg_latch_q <= 1'b0;
            rd_latch_q <= 1'b0;
            wd_latch_q <= 1'b0;
        end else begin
            if (write_gate_i && !wg_last_q) wg_latch_q <= 1'b1;
            else if (dig_in_rd) wg_latch_q <= 1'b0;
            if (rd_rise) rd_latch_q <= 1'b1;
            else if (dig_in_rd) rd_latch_q <= 1'b0;
            if (wd_rise) wd_latch_q <= 1'b1;
            else if (dig_in_rd) wd_latch_q <= 1'b0;
        end
    end

    always_comb begin
        case (mode_i)
            FDCR_MODE_ENHANCED: begin
                status_b = {2'b11, out_ctrl_q[FDCR_BIT_DRV_LO], wd_tog_q, rd_tog_q, write_gate_i,
                            ~motor_out_1_n_o, ~motor_out_0_n_o};
            end
            FDCR_MODE_LEGACY: begin
                status_b = {drv2_q, select_out_1_n_o, select_out_0_n_o, wd_latch_q, rd_latch_q,
                            wg_latch_q, 2'b11};
            end
            default: begin
                status_b = 8'h00;
            end
        endcase
    end

    always_comb begin
        case (out_ctrl_q[1:0])
            2'h0: type_id = drive_type_cfg_i[1:0];
            2'h1: type_id = drive_type_cfg_i[3:2];
            2'h2: type_id = drive_type_cfg_i[5:4];
            default: type_id = drive_type_cfg_i[7:6];
        endcase
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        oe_n_d = 1'b1;
        if (rd_i) begin
            case (addr_i)
                FDCR_ADDR_STATUS_B: begin
                    rdata_d = status_b;
                    oe_n_d = (mode_i == FDCR_MODE_BASIC_AT);
                end
                FDCR_ADDR_OUT_CTRL: begin
                    rdata_d = out_ctrl_q;
                    oe_n_d = 1'b0;
                end
                FDCR_ADDR_TAPE: begin
                    oe_n_d = 1'b0;
                    if (enh_floppy_i) rdata_d = {2'b00, type_id, boot_drive_i, tape_q};
                    else rdata_d = {6'h00, tape_q};
                end
                default: begin
                    rdata_d = 8'h00;
                    oe_n_d = 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    logic gate_en;
    assign gate_en = (mode_i == FDCR_MODE_ENHANCED) || out_ctrl_q[FDCR_BIT_DMA_GATE];

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
            rdata_oe_n_o <= 1'b1;
            select_out_0_n_o <= 1'b1;
            select_out_1_n_o <= 1'b1;
            motor_out_0_n_o <= 1'b1;
            motor_out_1_n_o <= 1'b1;
            soft_reset_o <= 1'b0;
            dma_req_o <= 1'b0;
            irq_o <= 1'b0;
            tape_sel_o <= FDCR_TAPE_RST;
        end else begin
            rdata_o <= rdata_d;
            rdata_oe_n_o <= oe_n_d;
            select_out_0_n_o <= sel0_n;
            select_out_1_n_o <= sel1_n;
            motor_out_0_n_o <= mot0_n;
            motor_out_1_n_o <= mot1_n;
            soft_reset_o <= !out_ctrl_q[FDCR_BIT_SRST_N] || (srst_cnt_q != 8'h00);
            dma_req_o <= dma_req_i && gate_en;
            irq_o <= irq_i && gate_en;
            tape_sel_o <= tape_q;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_basic_no_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_i && addr_i == FDCR_ADDR_STATUS_B && mode_i == FDCR_MODE_BASIC_AT |=> rdata_oe_n_o)
        else $error("status b driven in basic mode");
    a_one_select_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !(!select_out_0_n_o && !select_out_1_n_o))
        else $error("both selects active");
    a_srst_min_width: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(soft_reset_o) |-> soft_reset_o [*8])
        else $error("soft reset too short");
    a_ctrl_write_takes: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_i && addr_i == FDCR_ADDR_OUT_CTRL |=> out_ctrl_q == $past(wdata_i))
        else $error("output control write lost");
    a_latch_set_wins: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_rise |=> rd_latch_q)
        else $error("read data latch missed");
    a_motor_follow: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !swap_i && $stable(swap_i) |=> motor_out_0_n_o == !$past(out_ctrl_q[FDCR_BIT_MOTOR0]))
        else $error("motor 0 decode wrong");
    a_swap_select: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        swap_i && out_ctrl_q[1:0] == 2'h0 && out_ctrl_q[FDCR_BIT_MOTOR0] |=> !select_out_1_n_o)
        else $error("swapped select wrong");
    a_irq_gated: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mode_i != FDCR_MODE_ENHANCED && !out_ctrl_q[FDCR_BIT_DMA_GATE] |=> !irq_o && !dma_req_o)
        else $error("dma or irq not gated");
    a_rd_toggle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_rise |=> rd_tog_q != $past(rd_tog_q))
        else $error("read toggle missed");
    a_tape_normal_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_i && addr_i == FDCR_ADDR_TAPE && !enh_floppy_i |=> rdata_o[7:2] == 6'h00)
        else $error("tape upper bits nonzero");

    // length of the current soft reset pulse, saturating
    logic [7:0] srst_len_q;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !soft_reset_o) begin
            srst_len_q <= 8'h00;
        end else if (srst_len_q != 8'hFF) begin
            srst_len_q <= srst_len_q + 8'h01;
        end
    end

    a_srst_full_length: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(soft_reset_o) |-> srst_len_q >= 8'(FDCR_SRST_MIN_CYC))
        else $error("soft reset shorter than minimum");
endmodule

// ===== src/fdcr_pkg.sv
// constants for the drive control register bank
package fdcr_pkg;
    localparam logic [9:0] FDCR_ADDR_STATUS_B = 10'h3F1;
    localparam logic [9:0] FDCR_ADDR_OUT_CTRL = 10'h3F2;
    localparam logic [9:0] FDCR_ADDR_TAPE = 10'h3F3;
    localparam logic [9:0] FDCR_ADDR_DIG_IN = 10'h3F7;
    localparam logic [7:0] FDCR_OUT_CTRL_RST = 8'h00;
    localparam logic [1:0] FDCR_TAPE_RST = 2'h0;
    localparam int FDCR_BIT_DRV_LO = 0;
    localparam int FDCR_BIT_SRST_N = 2;
    localparam int FDCR_BIT_DMA_GATE = 3;
    localparam int FDCR_BIT_MOTOR0 = 4;
    localparam int FDCR_BIT_MOTOR1 = 5;
    localparam int FDCR_CLK_PERIOD_PS = 4000;
    localparam int FDCR_SRST_MIN_PS = 100000;
    localparam int FDCR_SRST_MIN_CYC = (FDCR_SRST_MIN_PS + FDCR_CLK_PERIOD_PS - 1) / FDCR_CLK_PERIOD_PS;
    typedef enum logic [1:0] {FDCR_MODE_BASIC_AT, FDCR_MODE_ENHANCED, FDCR_MODE_LEGACY} fdcr_mode_t;
endpackage

// ===== src/fdcr_edge_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser with rise and fall pulses
module fdcr_edge_sync (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire logic pin_i, // asynchronous input
    output logic rise_o, // one-cycle rising edge
    output logic fall_o // one-cycle falling edge
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            // lines watched here idle high; a zero reset would fake a rising edge
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise_o = sync_q & ~last_q;
    assign fall_o = ~sync_q & last_q;
endmodule

// ===== dv/fdcr_drive_model.sv
`timescale 1ns/1ps
// drive-side model: flux pulses from a selected, spinning drive
module fdcr_drive_model (
    input wire logic clk_sys_i, // system clock
    input wire logic select_out_0_n_i, // drive 0 select, active low
    input wire logic select_out_1_n_i, // drive 1 select, active low
    input wire logic motor_out_0_n_i, // motor 0, active low
    input wire logic motor_out_1_n_i, // motor 1, active low
    input wire logic pulse_i, // request one flux pulse
    output logic read_data_n_o // read data, active low, pulled up
);
    logic [1:0] cnt_q = 2'h0;
    logic spin;
    // an unselected or stopped drive sends nothing
    assign spin = (!select_out_0_n_i && !motor_out_0_n_i) || (!select_out_1_n_i && !motor_out_1_n_i);
    always_ff @(posedge clk_sys_i) begin
        if (pulse_i && spin) begin
            cnt_q <= 2'h3;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end
    // released line rests at the pull-up level
    assign read_data_n_o = (cnt_q == 2'h0);
endmodule

// ===== dv/floppy_drive_control_regs_tb.sv
`timescale 1ns/1ps
// self-checking bench for the drive control register bank
module floppy_drive_control_regs_tb
    import fdcr_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic rd_i = 1'b0;
    logic wr_i = 1'b0;
    logic swap_i = 1'b0;
    logic enh_floppy_i = 1'b0;
    logic write_gate_i = 1'b0;
    logic write_data_n_i = 1'b1;
    logic pulse = 1'b0;
    logic second_drive_present_n_i = 1'b1;
    logic dma_req_i = 1'b1;
    logic irq_i = 1'b1;
    logic [9:0] addr_i = 10'h000;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] drive_type_cfg_i = 8'hB4;
    logic [1:0] boot_drive_i = 2'h2;
    fdcr_mode_t mode_i = FDCR_MODE_BASIC_AT;
    logic [7:0] rdata_o;
    logic [7:0] d;
    logic [1:0] tape_sel_o;
    logic oen, rdata_oe_n_o, sel0, sel1, mot0, mot1, soft_reset_o, dma_req_o, irq_o, read_data_n;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;

    fdcr_regs fdcr_regs_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
        .wdata_i(wdata_i), .mode_i(mode_i), .swap_i(swap_i), .enh_floppy_i(enh_floppy_i),
        .drive_type_cfg_i(drive_type_cfg_i), .boot_drive_i(boot_drive_i), .write_gate_i(write_gate_i),
        .read_data_n_i(read_data_n), .write_data_n_i(write_data_n_i),
        .second_drive_present_n_i(second_drive_present_n_i),
        .dma_req_i(dma_req_i), .irq_i(irq_i), .rdata_o(rdata_o), .rdata_oe_n_o(rdata_oe_n_o),
        .select_out_0_n_o(sel0), .select_out_1_n_o(sel1), .motor_out_0_n_o(mot0), .motor_out_1_n_o(mot1),
        .soft_reset_o(soft_reset_o), .dma_req_o(dma_req_o), .irq_o(irq_o), .tape_sel_o(tape_sel_o));

    fdcr_drive_model fdcr_drive_model_i (.clk_sys_i(clk_sys_i), .select_out_0_n_i(sel0),
        .select_out_1_n_i(sel1), .motor_out_0_n_i(mot0), .motor_out_1_n_i(mot1), .pulse_i(pulse),
        .read_data_n_o(read_data_n));

    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // ----
    // helpers
    // ----
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // hang guard, well above the fewer than two hundred cycles the tests need
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        #1;
        addr_i = a;
        wdata_i = v;
        wr_i = 1'b1;
        wt(1);
        wr_i = 1'b0;
    endtask

    task automatic rd(input logic [9:0] a);
        @(posedge clk_sys_i);
        #1;
        addr_i = a;
        rd_i = 1'b1;
        wt(1);
        rd_i = 1'b0;
        d = rdata_o;
        oen = rdata_oe_n_o;
    endtask

    task automatic do_reset(input fdcr_mode_t m, input logic s, input logic e);
        @(posedge clk_sys_i);
        #1;
        rst_i = 1'b1;
        mode_i = m;
        swap_i = s;
        enh_floppy_i = e;
        wt(4);
        rst_i = 1'b0;
    endtask

    task automatic edges();
        pulse = 1'b1;
        write_data_n_i = 1'b0;
        wt(1);
        pulse = 1'b0;
        wt(3);
        write_data_n_i = 1'b1;
        wt(8);
    endtask

    // ----
    // scenarios
    // ----
    task automatic test_basic();
        int n;
        do_reset(FDCR_MODE_BASIC_AT, 1'b0, 1'b0);
        rd(FDCR_ADDR_STATUS_B);
        chk({7'h00, oen}, 8'h01, "status b driven");
        rd(FDCR_ADDR_OUT_CTRL);
        chk({oen, d[6:0]}, 8'h00, "out ctrl reset");
        chk({7'h00, soft_reset_o}, 8'h01, "reset not held");
        wr(FDCR_ADDR_TAPE, 8'hFF);
        wr(FDCR_ADDR_OUT_CTRL, 8'h1C);
        wt(3);
        chk({4'h0, sel1, sel0, mot1, mot0}, 8'h0A, "drive 0 decode");
        chk({6'h00, dma_req_o, irq_o}, 8'h03, "gate open");
        wr(FDCR_ADDR_OUT_CTRL, 8'h2D);
        wt(3);
        chk({4'h0, sel1, sel0, mot1, mot0}, 8'h05, "drive 1 decode");
        wr(FDCR_ADDR_OUT_CTRL, 8'h01);
        wr(FDCR_ADDR_OUT_CTRL, 8'h05);
        chk({4'h0, sel1, sel0, mot1, mot0}, 8'h0F, "no select");
        chk({6'h00, dma_req_o, irq_o}, 8'h00, "gate closed");
        chk({7'h00, soft_reset_o}, 8'h01, "pulse lost");
        n = 0;
        while (soft_reset_o === 1'b1 && n < 40) begin
            wt(1);
            n++;
        end
        chk({7'h00, n >= 24 && n <= 30}, 8'h01, "soft reset length");
        rd(FDCR_ADDR_OUT_CTRL);
        chk(d, 8'h05, "out ctrl after soft reset");
        rd(FDCR_ADDR_TAPE);
        chk(d, 8'h03, "tape read");
        chk({6'h00, tape_sel_o}, 8'h03, "tape select");
        rd(10'h3F5);
        chk({7'h00, oen}, 8'h01, "unmapped driven");
        $display("test basic done");
    endtask

    task automatic test_swap();
        do_reset(FDCR_MODE_BASIC_AT, 1'b1, 1'b0);
        wr(FDCR_ADDR_OUT_CTRL, 8'h1C);
        wt(3);
        chk({4'h0, sel1, sel0, mot1, mot0}, 8'h05, "swap drive 0");
        wr(FDCR_ADDR_OUT_CTRL, 8'h2D);
        wt(3);
        chk({4'h0, sel1, sel0, mot1, mot0}, 8'h0A, "swap drive 1");
        $display("test swap done");
    endtask

    task automatic test_enh();
        do_reset(FDCR_MODE_ENHANCED, 1'b0, 1'b1);
        rd(FDCR_ADDR_STATUS_B);
        chk(d, 8'hC0, "enhanced reset");
        chk({7'h00, oen}, 8'h00, "enhanced status b undriven");
        wr(FDCR_ADDR_OUT_CTRL, 8'h35);
        wt(3);
        chk({7'h00, dma_req_o}, 8'h01, "enhanced gate");
        rd(FDCR_ADDR_STATUS_B);
        chk(d, 8'hE3, "motor and select");
        edges();
        rd(FDCR_ADDR_STATUS_B);
        chk(d, 8'hFB, "toggles");
        write_gate_i = 1'b1;
        wt(2);
        rd(FDCR_ADDR_STATUS_B);
        chk(d, 8'hFF, "live write gate");
        write_gate_i = 1'b0;
        wr(FDCR_ADDR_TAPE, 8'h02);
        rd(FDCR_ADDR_TAPE);
        chk(d, 8'h1A, "enhanced tape");
        $display("test enhanced done");
    endtask

    task automatic test_legacy();
        do_reset(FDCR_MODE_LEGACY, 1'b0, 1'b0);
        rd(FDCR_ADDR_STATUS_B);
        chk(d, 8'hE3, "legacy reset");
        chk({7'h00, oen}, 8'h00, "legacy status b undriven");
        wr(FDCR_ADDR_OUT_CTRL, 8'h1C);
        wt(3);
        write_gate_i = 1'b1;
        wt(4);
        rd(FDCR_ADDR_STATUS_B);
        chk(d, 8'hC7, "write gate latch");
        rd(FDCR_ADDR_DIG_IN);
        rd(FDCR_ADDR_STATUS_B);
        chk(d, 8'hC3, "latch clear");
        write_gate_i = 1'b0;
        edges();
        rd(FDCR_ADDR_STATUS_B);
        chk(d, 8'hDB, "data latches");
        rd(FDCR_ADDR_DIG_IN);
        rd(FDCR_ADDR_STATUS_B);
        chk(d, 8'hC3, "data latch clear");
        second_drive_present_n_i = 1'b0;
        wt(3);
        rd(FDCR_ADDR_STATUS_B);
        chk(d, 8'h43, "drive 2 input");
        $display("test legacy done");
    endtask

    initial begin
        test_basic();
        test_swap();
        test_enh();
        test_legacy();
        wrap_up();
    end
endmodule
